// ===== rtl/timer8_pkg.sv
// timer8_pkg: shared constants for the 8-bit waveform timer.
// assumes a 100 MHz system clock and an Avalon-MM register port.
package timer8_pkg;

  // ----------------------------------------------------------------
  // counting modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PHASE,
    MODE_CTC,
    MODE_FAST
  } mode_type;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_COUNT = 5'h04;
  localparam logic [4:0] REG_COMPARE = 5'h08;
  localparam logic [4:0] REG_FLAGS = 5'h0c;
  localparam logic [4:0] REG_PIN = 5'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int ACTION_LSB = 2;
  localparam int CLKSEL_LSB = 4;
  localparam int FORCE_BIT = 7;
  localparam int OVF_BIT = 0;
  localparam int CMF_BIT = 1;
  localparam int DIR_BIT = 0;
  localparam int PORT_BIT = 1;
  localparam int WAVE_BIT = 2;
  localparam int PINLVL_BIT = 3;

  // ----------------------------------------------------------------
  // counter values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  localparam logic [2:0] CLKSEL_RST = 3'h0;
  localparam logic [1:0] ACTION_RST = 2'h0;

  // ----------------------------------------------------------------
  // prescaler: clock select codes and divider widths (log2 of factor)
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_DIV1 = 3'h1;
  localparam logic [2:0] SEL_DIV8 = 3'h2;
  localparam logic [2:0] SEL_DIV64 = 3'h3;
  localparam logic [2:0] SEL_DIV256 = 3'h4;
  localparam logic [2:0] SEL_DIV1024 = 3'h5;
  localparam int DIV8_BITS = 3;
  localparam int DIV64_BITS = 6;
  localparam int DIV256_BITS = 8;
  localparam int DIV1024_BITS = 10;

endpackage

// ===== rtl/timer8_prescaler.sv
// timer8_prescaler: turns the clock select code into a tick enable.
// assumes one system clock; the tick is a one-cycle enable pulse.
`timescale 1ns/1ns
module timer8_prescaler
  import timer8_pkg::*;
#(
  parameter int DIV_W = DIV1024_BITS
)
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [2:0] clk_sel_in,
  output logic tick_out
);

  logic [DIV_W-1:0] div_r;

  // ----------------------------------------------------------------
  // free-running divider
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  // tick at the last count of each division window; other codes stop
  always_comb
  begin
    case (clk_sel_in)
      SEL_DIV1: tick_out = 1'b1;
      SEL_DIV8: tick_out = &div_r[DIV8_BITS-1:0];
      SEL_DIV64: tick_out = &div_r[DIV64_BITS-1:0];
      SEL_DIV256: tick_out = &div_r[DIV256_BITS-1:0];
      SEL_DIV1024: tick_out = &div_r[DIV1024_BITS-1:0];
      default: tick_out = 1'b0;
    endcase
  end

endmodule

// ===== rtl/timer8_sticky_flag.sv
// timer8_sticky_flag: one event flag, set by hardware, cleared by software.
// assumes set and clear are single-cycle strobes on the same clock.
`timescale 1ns/1ns
module timer8_sticky_flag
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);

  // ----------------------------------------------------------------
  // flag storage: a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clear_in)
      flag_out <= 1'b0;
  end

endmodule

// ===== rtl/timer8_waveform_modes.sv
// timer8_waveform_modes: 8-bit timer with one compare channel, driving a
// waveform pin in normal, clear-on-match, fast and phase-correct modes.
// assumes an Avalon-MM master on sys_clk_in and a pin pad outside.
//
// Behaviour
// - mode 2 clears the counter on compare match; compare is top
// - mode 2 compare unbuffered; lowered below count, count wraps via 0xFF
// - mode 2 sets compare match flag at every top
// - mode 2 action 1 toggles output on each match
// - pin driven only while direction bit selects output
// - mode 2 sets overflow flag on the roll from MAX to 0x00
// - mode 3 counts BOTTOM to MAX then restarts, 256 ticks
// - mode 3 non-inverting clears on match, sets at BOTTOM; inverting opposite
// - mode 3 action two non-inverted, action three inverted
// - mode 3 increments to MAX then clears on next tick
// - mode 3 sets overflow flag each time counter reaches MAX
// - mode 3 compare BOTTOM gives spike; compare MAX gives constant level
// - mode 3 action 1 toggles on match, compare still double buffered
// - mode 1 counts up to MAX then down to BOTTOM, 510 ticks
// - mode 1 action two clears on up match, sets on down match
// - mode 1 turns at MAX, holding MAX for one tick
// - mode 1 sets overflow flag when counter reaches BOTTOM
// - mode 1 compare BOTTOM constant low, MAX constant high, non-inverting
// - mode 1 forces up-match level at MAX turnaround without match
// - mode 1 missed up match still gets its output transition
// - counter advances only on prescaler ticks of 1, 8, 64, 256, 1024
// - PWM modes buffer compare writes to period boundary; others immediate
// - compare match flag set on the tick after a match
// - a counter write blocks compare matches in the next tick
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module timer8_waveform_modes
  import timer8_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic waveform_pin_out,
  output logic waveform_pin_oe_out,
  output logic overflow_flag_out,
  output logic compare_match_flag_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdata_r;
  logic wr_stb;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_pin;
  logic force_stb;
  mode_type waveform_mode_sel;
  logic [1:0] compare_out_action;
  logic [2:0] clk_sel_r;
  logic dir_out_r;
  logic port_data_r;
  logic [7:0] count_value;
  logic [7:0] compare_buf_r;
  logic [7:0] compare_value;
  logic down_r;
  logic block_r;
  logic waveform_output;
  logic tick;
  logic is_pwm;
  logic cnt_max;
  logic cnt_bot;
  logic cmp_max;
  logic cmp_bot;
  logic match;
  logic ovf_set;
  logic cmf_set;
  logic [7:0] wdata;

  // ----------------------------------------------------------------
  // action helper for non-PWM modes: toggle, clear or set
  // ----------------------------------------------------------------
  function automatic logic non_pwm_action(input logic [1:0] act, input logic cur);
    logic res;
    begin
      res = cur;
      case (act)
        2'h1: res = ~cur;
        2'h2: res = 1'b0;
        2'h3: res = 1'b1;
        default: res = cur;
      endcase
      return res;
    end
  endfunction

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the answer
  // ----------------------------------------------------------------

  // answer one cycle after a request is seen
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign avs_readdata_out = rdata_r;

  // writes take effect at the edge where waitrequest is low
  assign wdata = avs_writedata_in[7:0];
  assign wr_stb = avs_write_in & ack_r & avs_byteenable_in[0];
  assign wr_ctrl = wr_stb & (avs_address_in == REG_CTRL);
  assign wr_count = wr_stb & (avs_address_in == REG_COUNT);
  assign wr_compare = wr_stb & (avs_address_in == REG_COMPARE);
  assign wr_flags = wr_stb & (avs_address_in == REG_FLAGS);
  assign wr_pin = wr_stb & (avs_address_in == REG_PIN);
  assign force_stb = wr_ctrl & wdata[FORCE_BIT];

  // read data captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      rdata_r <= '0;
    else if (avs_read_in & ~ack_r)
    begin
      rdata_r <= '0;
      case (avs_address_in)
        REG_CTRL:
        begin
          rdata_r[MODE_LSB +: 2] <= waveform_mode_sel;
          rdata_r[ACTION_LSB +: 2] <= compare_out_action;
          rdata_r[CLKSEL_LSB +: 3] <= clk_sel_r;
        end
        REG_COUNT: rdata_r[7:0] <= count_value;
        REG_COMPARE: rdata_r[7:0] <= compare_buf_r;
        REG_FLAGS:
        begin
          rdata_r[OVF_BIT] <= overflow_flag_out;
          rdata_r[CMF_BIT] <= compare_match_flag_out;
        end
        REG_PIN:
        begin
          rdata_r[DIR_BIT] <= dir_out_r;
          rdata_r[PORT_BIT] <= port_data_r;
          rdata_r[WAVE_BIT] <= waveform_output;
          rdata_r[PINLVL_BIT] <= waveform_pin_out;
        end
        default: rdata_r <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control and pin registers
  // ----------------------------------------------------------------

  // mode, output action and clock select
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      waveform_mode_sel <= MODE_NORMAL;
      compare_out_action <= ACTION_RST;
      clk_sel_r <= CLKSEL_RST;
    end
    else if (wr_ctrl)
    begin
      waveform_mode_sel <= mode_type'(wdata[MODE_LSB +: 2]);
      compare_out_action <= wdata[ACTION_LSB +: 2];
      clk_sel_r <= wdata[CLKSEL_LSB +: 3];
    end
  end

  // pin direction and plain port level
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      dir_out_r <= 1'b0;
      port_data_r <= 1'b0;
    end
    else if (wr_pin)
    begin
      dir_out_r <= wdata[DIR_BIT];
      port_data_r <= wdata[PORT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // prescaler tick
  // ----------------------------------------------------------------
  // prescaled tick enable
  timer8_prescaler #(
    .DIV_W(DIV1024_BITS)
  ) u_prescaler (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .clk_sel_in(clk_sel_r),
    .tick_out(tick)
  );

  // ----------------------------------------------------------------
  // decode of counter and compare state
  // ----------------------------------------------------------------
  assign is_pwm = (waveform_mode_sel == MODE_FAST) | (waveform_mode_sel == MODE_PHASE);
  assign cnt_max = (count_value == CNT_MAX);
  assign cnt_bot = (count_value == CNT_BOTTOM);
  assign cmp_max = (compare_value == CNT_MAX);
  assign cmp_bot = (compare_value == CNT_BOTTOM);
  assign match = tick & (count_value == compare_value) & ~block_r;

  // ----------------------------------------------------------------
  // match blocking after a counter write
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      block_r <= 1'b0;
    else if (wr_count)
      block_r <= 1'b1;
    else if (tick)
      block_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // counter and count direction
  // ----------------------------------------------------------------
  // tick-enabled counter
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      count_value <= CNT_BOTTOM;
      down_r <= 1'b0;
    end
    else if (wr_count)
      count_value <= wdata;
    else if (tick)
    begin
      case (waveform_mode_sel)
        MODE_CTC:
        begin
          down_r <= 1'b0;
          if (match)
            count_value <= CNT_BOTTOM;
          else
            count_value <= count_value + CNT_ONE;
        end
        MODE_PHASE:
        begin
          if (!down_r && cnt_max)
          begin
            count_value <= CNT_MAX - CNT_ONE;
            down_r <= 1'b1;
          end
          else if (down_r && cnt_bot)
          begin
            count_value <= CNT_ONE;
            down_r <= 1'b0;
          end
          else if (down_r)
            count_value <= count_value - CNT_ONE;
          else
            count_value <= count_value + CNT_ONE;
        end
        default:
        begin
          down_r <= 1'b0;
          count_value <= count_value + CNT_ONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // compare value and its buffer
  // ----------------------------------------------------------------
  // buffered compare
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      compare_buf_r <= COMPARE_RST;
      compare_value <= COMPARE_RST;
    end
    else
    begin
      if (wr_compare)
        compare_buf_r <= wdata;
      if (wr_compare && !is_pwm)
        compare_value <= wdata;
      else if (tick && !wr_count && cnt_max && !down_r && is_pwm)
        compare_value <= (wr_compare) ? wdata : compare_buf_r;
    end
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  // MAX roll; in phase-correct mode, the down count reaching BOTTOM
  assign ovf_set = tick & ~wr_count &
    ((waveform_mode_sel == MODE_PHASE) ? (down_r & (count_value == CNT_ONE)) : cnt_max);
  assign cmf_set = match & ~wr_count;

  timer8_sticky_flag u_overflow_flag (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .set_in(ovf_set),
    .clear_in(wr_flags & wdata[OVF_BIT]),
    .flag_out(overflow_flag_out)
  );

  timer8_sticky_flag u_compare_flag (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .set_in(cmf_set),
    .clear_in(wr_flags & wdata[CMF_BIT]),
    .flag_out(compare_match_flag_out)
  );

  // ----------------------------------------------------------------
  // waveform generator
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      waveform_output <= 1'b0;
    else if (force_stb && !is_pwm)
      waveform_output <= non_pwm_action(compare_out_action, waveform_output);
    else if (tick)
    begin
      case (waveform_mode_sel)
        MODE_FAST:
        begin
          if (compare_out_action == 2'h1)
          begin
            if (match)
              waveform_output <= ~waveform_output;
          end
          else if (compare_out_action[1])
          begin
            if (cnt_max && !wr_count)
              waveform_output <= ~compare_out_action[0];
            else if (match && !cmp_max)
              waveform_output <= compare_out_action[0];
          end
        end
        MODE_PHASE:
        begin
          if (compare_out_action[1])
          begin
            if (!down_r && cnt_max && !wr_count)
              waveform_output <= cmp_max ? ~compare_out_action[0] : compare_out_action[0];
            else if (match && !down_r)
              waveform_output <= compare_out_action[0];
            else if (match && down_r && !cmp_bot)
              waveform_output <= ~compare_out_action[0];
          end
        end
        default:
        begin
          if (match)
            waveform_output <= non_pwm_action(compare_out_action, waveform_output);
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin override
  // ----------------------------------------------------------------
  // driven when output
  assign waveform_pin_oe_out = dir_out_r;
  assign waveform_pin_out = (compare_out_action != ACTION_RST) ? waveform_output : port_data_r;

endmodule

// ===== dv/timer8_monitor.sv
// timer8_monitor: port-level assertions for the waveform timer.
// assumes only the top module's ports; bound at the foot of this file.
`timescale 1ns/1ns
module timer8_monitor
  import timer8_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic waveform_pin_out,
  input wire logic waveform_pin_oe_out,
  input wire logic overflow_flag_out,
  input wire logic compare_match_flag_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic wr_done;
  logic stop_r;
  logic [3:0] stop_cnt_r;
  logic stopped;
  // a write that completes at this edge
  assign wr_done = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign stopped = stop_r && (stop_cnt_r > 4'h2);
  // tracks how long the clock select has been stopped
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      stop_r <= 1'b1;
      stop_cnt_r <= 4'hf;
    end
    else if (wr_done && avs_address_in == REG_CTRL)
    begin
      stop_r <= (avs_writedata_in[6:4] == 3'h0) || (avs_writedata_in[6:4] > 3'h5);
      stop_cnt_r <= 4'h0;
    end
    else if (stop_cnt_r != 4'hf)
      stop_cnt_r <= stop_cnt_r + 4'h1;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RD_WAIT: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read not answered after one wait cycle");
  AST_WR_WAIT: assert property (avs_write_in && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("write held in wait too long");
  AST_IDLE: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("wait raised with no request");
  AST_RD_HI: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_RD_HOLD: assert property ($changed(avs_readdata_out) |-> $past(avs_read_in && avs_waitrequest_out))
    else $error("read data changed without a read");
  AST_OE: assert property ($changed(waveform_pin_oe_out) |-> $past(wr_done && avs_address_in == REG_PIN))
    else $error("pin enable changed without a pin write");
  AST_OVF_CLR: assert property ($fell(overflow_flag_out) |-> $past(wr_done && avs_address_in == REG_FLAGS && avs_writedata_in[OVF_BIT]))
    else $error("overflow flag dropped without a clear");
  AST_CMF_CLR: assert property ($fell(compare_match_flag_out) |-> $past(wr_done && avs_address_in == REG_FLAGS && avs_writedata_in[CMF_BIT]))
    else $error("compare flag dropped without a clear");
  AST_STOP_FLAG: assert property (stopped |-> !$rose(overflow_flag_out) && !$rose(compare_match_flag_out))
    else $error("flag set while timer stopped");
  AST_STOP_PIN: assert property (stopped && !$past(wr_done) |-> $stable(waveform_pin_out))
    else $error("pin moved while timer stopped");
endmodule
bind timer8_waveform_modes timer8_monitor u_timer8_monitor (.sys_clk_in, .rstn_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
  .avs_readdata_out, .avs_waitrequest_out, .waveform_pin_out, .waveform_pin_oe_out,
  .overflow_flag_out, .compare_match_flag_out);

// ===== dv/tb_top.sv
// tb_top: directed bench for the waveform timer over its register port.
// assumes the monitor is bound to the design; clock select /1 unless noted.
`timescale 1ns/1ns
module tb_top
  import timer8_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, waveform_pin_out, waveform_pin_oe_out;
  logic overflow_flag_out, compare_match_flag_out;
  int cyc = 0;
  int n_errors = 0;
  int check_count = 0;
  int n;
  timer8_waveform_modes u_timer8_waveform_modes (.sys_clk_in, .rstn_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .waveform_pin_out, .waveform_pin_oe_out, .overflow_flag_out,
    .compare_match_flag_out);
  // ----------------------------------------------------------------
  // clock, cycle count and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  initial
  begin
    #500000;
    n_errors++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one Avalon-MM cycle, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= 4'h1;
    avs_write_in <= w;
    avs_read_in <= !w;
    // waitrequest and read data as they stand at each rising edge
    do
      @(posedge sys_clk_in);
    while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, {24'h0, e});
  endtask
  function automatic logic sig(input int s);
    return (s == 0) ? waveform_pin_out : ((s == 1) ? overflow_flag_out : compare_match_flag_out);
  endfunction
  // waits on pin (0), overflow (1) or compare flag (2) for a level
  task automatic wait_lvl(input int s, input logic l);
    int i;
    i = 0;
    do
    begin
      @(negedge sys_clk_in);
      i++;
    end
    while (sig(s) !== l && i < 5000);
    check(sig(s), l);
  endtask
  task automatic pin_len(input logic l, input int e);
    int t;
    wait_lvl(0, !l);
    wait_lvl(0, l);
    t = cyc;
    wait_lvl(0, !l);
    check(cyc - t, e);
  endtask
  task automatic hold(input logic l);
    logic ok;
    ok = 1'b1;
    repeat (600)
    begin
      @(negedge sys_clk_in);
      if (waveform_pin_out !== l)
        ok = 1'b0;
    end
    check(ok, 1'b1);
  endtask
  task automatic ovf_per(input int e);
    int t;
    wreg(REG_FLAGS, 8'h01);
    wait_lvl(1, 1'b1);
    t = cyc;
    wreg(REG_FLAGS, 8'h01);
    wait_lvl(1, 1'b1);
    check(cyc - t, e);
  endtask
  // stop, load compare in normal mode, restart from zero in a new mode
  task automatic cfg(input mode_type m, input logic [1:0] act, input logic [2:0] sel,
    input logic [7:0] c);
    wreg(REG_CTRL, 8'h00);
    wreg(REG_COUNT, 8'h00);
    wreg(REG_COMPARE, c);
    wreg(REG_FLAGS, 8'h03);
    wreg(REG_CTRL, {1'b0, sel, act, m});
    repeat (600) @(posedge sys_clk_in);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 24; a += 4) rchk(a[4:0], 8'h00);
    check({waveform_pin_out, waveform_pin_oe_out, overflow_flag_out, compare_match_flag_out}, 0);
  endtask
  task automatic t_ctc();
    wreg(REG_PIN, 8'h01);
    @(negedge sys_clk_in);
    check(waveform_pin_oe_out, 1'b1);
    cfg(MODE_CTC, 2'h1, SEL_DIV1, 8'h00);
    pin_len(1'b1, 1);
    cfg(MODE_CTC, 2'h1, SEL_DIV1, 8'h04);
    pin_len(1'b1, 5);
    pin_len(1'b0, 5);
    wreg(REG_FLAGS, 8'h02);
    wait_lvl(2, 1'b1);
    wreg(REG_PIN, 8'h00);
    @(negedge sys_clk_in);
    check(waveform_pin_oe_out, 1'b0);
  endtask
  task automatic t_ctc_miss();
    wreg(REG_CTRL, 8'h00);
    wreg(REG_COUNT, 8'h0a);
    wreg(REG_COMPARE, 8'h05);
    wreg(REG_FLAGS, 8'h03);
    wreg(REG_CTRL, {1'b0, SEL_DIV1, 2'h0, MODE_CTC});
    wait_lvl(1, 1'b1);
    n = cyc;
    check(compare_match_flag_out, 1'b0);
    wait_lvl(2, 1'b1);
    check(cyc - n, 6);
    // count written equal to compare while stopped: first tick must not match
    wreg(REG_CTRL, 8'h00);
    wreg(REG_COUNT, 8'h05);
    wreg(REG_FLAGS, 8'h03);
    wreg(REG_CTRL, {1'b0, SEL_DIV1, 2'h0, MODE_CTC});
    repeat (20) @(negedge sys_clk_in);
    check(compare_match_flag_out, 1'b0);
    // action 0 leaves the pin to the port data bit
    wreg(REG_PIN, 8'h02);
    @(negedge sys_clk_in);
    check(waveform_pin_out, 1'b1);
  endtask
  task automatic t_fast();
    // set at bottom, clear at match
    cfg(MODE_FAST, 2'h2, SEL_DIV1, 8'h40);
    pin_len(1'b1, 65);
    pin_len(1'b0, 191);
    ovf_per(256);
    // compare lowered just after the wrap: this period keeps the old value
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    n = cyc;
    wreg(REG_COMPARE, 8'h10);
    wait_lvl(0, 1'b0);
    check(cyc - n, 65);
    pin_len(1'b1, 17);
    rchk(REG_COMPARE, 8'h10);
    cfg(MODE_FAST, 2'h3, SEL_DIV1, 8'h40);
    pin_len(1'b0, 65);
    cfg(MODE_FAST, 2'h2, SEL_DIV1, 8'hff);
    hold(1'b1);
    cfg(MODE_FAST, 2'h3, SEL_DIV1, 8'hff);
    hold(1'b0);
    cfg(MODE_FAST, 2'h2, SEL_DIV1, 8'h00);
    pin_len(1'b1, 1);
    cfg(MODE_FAST, 2'h1, SEL_DIV1, 8'h00);
    pin_len(1'b1, 256);
    cfg(MODE_FAST, 2'h2, SEL_DIV8, 8'h40);
    ovf_per(2048);
  endtask
  task automatic t_phase();
    cfg(MODE_PHASE, 2'h2, SEL_DIV1, 8'h64);
    pin_len(1'b1, 200);
    pin_len(1'b0, 310);
    ovf_per(510);
    cfg(MODE_PHASE, 2'h3, SEL_DIV1, 8'h64);
    pin_len(1'b0, 200);
    cfg(MODE_PHASE, 2'h2, SEL_DIV1, 8'h00);
    hold(1'b0);
    cfg(MODE_PHASE, 2'h2, SEL_DIV1, 8'hff);
    hold(1'b1);
    cfg(MODE_PHASE, 2'h3, SEL_DIV1, 8'h00);
    hold(1'b1);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_ctc();
    t_ctc_miss();
    t_fast();
    t_phase();
    end_of_test();
  end
endmodule
